/* File: hw/phyanr_pkg.sv */
package phyanr_pkg;
    // register numbers on the management port
    localparam logic [4:0]  ADDR_EXPANSION   = 5'h06;
    localparam logic [4:0]  ADDR_CONFIG      = 5'h10;
    localparam logic [4:0]  ADDR_IRQ_STATUS  = 5'h1E;
    localparam logic [4:0]  ADDR_IRQ_MASK    = 5'h1F;
    // expansion fields
    localparam int          EXP_FAULT_BIT    = 4;
    localparam int          EXP_LP_NP_BIT    = 3;
    localparam int          EXP_LOC_NP_BIT   = 2;
    localparam int          EXP_PAGE_BIT     = 1;
    localparam int          EXP_LP_AN_BIT    = 0;
    localparam logic        LOCAL_NP_VALUE   = 1'b0;
    // configuration fields
    localparam int          CFG_CODER_BIT    = 15;
    localparam int          CFG_SCR_BIT      = 14;
    localparam int          CFG_ALIGN_BIT    = 13;
    localparam int          CFG_SD_BIT       = 12;
    localparam int          CFG_TX_BIT       = 10;
    localparam int          CFG_FLINK_BIT    = 7;
    localparam int          CFG_APD_BIT      = 4;
    localparam int          CFG_STATE_MACHINE_RESET_BIT    = 3;
    localparam int          CFG_PRE_BIT      = 2;
    localparam int          CFG_SLEEP_BIT    = 1;
    localparam int          CFG_LOOP_BIT     = 0;
    localparam logic [15:0] CFG_RESET        = 16'h0410;
    localparam logic [15:0] CFG_WRITE_MASK   = 16'hF09F;
    // interrupt status bits: 0 fault, 1 page received
    localparam int          IRQ_FAULT_BIT    = 0;
    localparam int          IRQ_PAGE_BIT     = 1;
    localparam logic [1:0]  IRQ_MASK_RESET   = 2'h0;
    // state-machine reset pulse length in cycles
    localparam logic [3:0]  STATE_MACHINE_RESET_CYCLES     = 4'h8;
endpackage : phyanr_pkg

/* File: hw/phyanr_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module phyanr_regs (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [4:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    input  wire logic        parallel_fault_event,
    input  wire logic        page_received_event,
    input  wire logic        partner_next_page_able,
    input  wire logic        partner_autoneg_able,
    input  wire logic        line_signal_detect,
    input  wire logic        line_link_100_ok,
    input  wire logic        idle_power_condition,
    output logic             bypass_block_coder,
    output logic             bypass_scrambler,
    output logic             bypass_descrambler,
    output logic             bypass_symbol_alignment,
    output logic             bypass_symbol_coding,
    output logic             signal_detect,
    output logic             link_100_good,
    output logic             auto_power_reduce,
    output logic             state_machine_reset,
    output logic             mgmt_preamble_suppress,
    output logic             sleep_power_down,
    output logic             remote_loopout,
    output logic             irq
);
    logic [15:0] cfg;
    logic        fault_latch;
    logic        page_latch;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [3:0]  state_machine_reset_count;
    logic        state_machine_reset_busy;
    logic        wake_reset;
    logic        rd_exp;
    logic        rd_irq;
    logic        wr_cfg;
    logic [15:0] next_rdata;

    assign rd_exp = reg_read && reg_addr == phyanr_pkg::ADDR_EXPANSION;
    assign rd_irq = reg_read && reg_addr == phyanr_pkg::ADDR_IRQ_STATUS;
    assign wr_cfg = reg_write && reg_addr == phyanr_pkg::ADDR_CONFIG;
    // wake from sleep: write clearing a set sleep bit
    assign wake_reset = wr_cfg && cfg[phyanr_pkg::CFG_SLEEP_BIT]
                        && !reg_wdata[phyanr_pkg::CFG_SLEEP_BIT];

    // set wins over the read clear so no event is lost
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fault_latch <= 1'b0;
        end else if (parallel_fault_event) begin
            fault_latch <= 1'b1;
        end else if (rd_exp) begin
            fault_latch <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            page_latch <= 1'b0;
        end else if (page_received_event) begin
            page_latch <= 1'b1;
        end else if (rd_exp) begin
            page_latch <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= (rd_irq ? 2'h0 : irq_status)
                          | {page_received_event, parallel_fault_event};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_mask <= phyanr_pkg::IRQ_MASK_RESET;
        end else if (reg_write && reg_addr == phyanr_pkg::ADDR_IRQ_MASK) begin
            irq_mask <= reg_wdata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // reserved and read-only bits ignore writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg <= phyanr_pkg::CFG_RESET;
        end else if (wr_cfg) begin
            cfg <= (reg_wdata & phyanr_pkg::CFG_WRITE_MASK)
                   | (phyanr_pkg::CFG_RESET & ~phyanr_pkg::CFG_WRITE_MASK);
        end else if (state_machine_reset_count == 4'h1) begin
            cfg[phyanr_pkg::CFG_STATE_MACHINE_RESET_BIT] <= 1'b0;
        end
    end

    // counter holds the machine reset for a fixed pulse
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_machine_reset_count <= 4'h0;
        end else if ((wr_cfg && reg_wdata[phyanr_pkg::CFG_STATE_MACHINE_RESET_BIT]) || wake_reset) begin
            state_machine_reset_count <= phyanr_pkg::STATE_MACHINE_RESET_CYCLES;
        end else if (state_machine_reset_count != 4'h0) begin
            state_machine_reset_count <= state_machine_reset_count - 4'h1;
        end
    end
    assign state_machine_reset_busy = state_machine_reset_count != 4'h0;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bypass_block_coder      <= 1'b0;
            bypass_scrambler        <= 1'b0;
            bypass_descrambler      <= 1'b0;
            bypass_symbol_alignment <= 1'b0;
            bypass_symbol_coding    <= 1'b0;
            signal_detect           <= 1'b0;
            link_100_good           <= 1'b0;
            auto_power_reduce       <= 1'b0;
            state_machine_reset     <= 1'b0;
            mgmt_preamble_suppress  <= 1'b0;
            sleep_power_down        <= 1'b0;
            remote_loopout          <= 1'b0;
        end else begin
            bypass_block_coder      <= cfg[phyanr_pkg::CFG_CODER_BIT]
                                       || cfg[phyanr_pkg::CFG_ALIGN_BIT];
            bypass_scrambler        <= cfg[phyanr_pkg::CFG_SCR_BIT]
                                       || cfg[phyanr_pkg::CFG_ALIGN_BIT];
            bypass_descrambler      <= cfg[phyanr_pkg::CFG_SCR_BIT]
                                       || cfg[phyanr_pkg::CFG_ALIGN_BIT];
            bypass_symbol_alignment <= cfg[phyanr_pkg::CFG_ALIGN_BIT];
            bypass_symbol_coding    <= cfg[phyanr_pkg::CFG_ALIGN_BIT];
            signal_detect           <= line_signal_detect
                                       || cfg[phyanr_pkg::CFG_SD_BIT];
            link_100_good           <= line_link_100_ok
                                       || cfg[phyanr_pkg::CFG_FLINK_BIT];
            auto_power_reduce       <= idle_power_condition
                                       && cfg[phyanr_pkg::CFG_APD_BIT];
            state_machine_reset     <= state_machine_reset_busy;
            mgmt_preamble_suppress  <= cfg[phyanr_pkg::CFG_PRE_BIT];
            sleep_power_down        <= cfg[phyanr_pkg::CFG_SLEEP_BIT];
            remote_loopout          <= cfg[phyanr_pkg::CFG_LOOP_BIT];
        end
    end

    // whole sixteen-bit words only, unmapped reads give zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (reg_addr)
            phyanr_pkg::ADDR_EXPANSION: begin
                next_rdata[phyanr_pkg::EXP_FAULT_BIT]  = fault_latch;
                next_rdata[phyanr_pkg::EXP_LP_NP_BIT]  = partner_next_page_able;
                next_rdata[phyanr_pkg::EXP_LOC_NP_BIT] = phyanr_pkg::LOCAL_NP_VALUE;
                next_rdata[phyanr_pkg::EXP_PAGE_BIT]   = page_latch;
                next_rdata[phyanr_pkg::EXP_LP_AN_BIT]  = partner_autoneg_able;
            end
            phyanr_pkg::ADDR_CONFIG: begin
                next_rdata = cfg;
                next_rdata[phyanr_pkg::CFG_TX_BIT] = 1'b1;
            end
            phyanr_pkg::ADDR_IRQ_STATUS: next_rdata[1:0] = irq_status;
            phyanr_pkg::ADDR_IRQ_MASK:   next_rdata[1:0] = irq_mask;
            default:                     next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    sequence fault_then_read_s;
        parallel_fault_event ##1 (reg_read && reg_addr == phyanr_pkg::ADDR_EXPANSION);
    endsequence

    fault_latch_a: assert property (@(posedge clk_sys) disable iff (reset)
        fault_then_read_s |=> reg_rdata[phyanr_pkg::EXP_FAULT_BIT])
        else $error("fault bit not reported");
    fault_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (rd_exp && !parallel_fault_event) |=> !fault_latch)
        else $error("fault bit not cleared by read");
    partner_np_a: assert property (@(posedge clk_sys) disable iff (reset)
        rd_exp |=> reg_rdata[phyanr_pkg::EXP_LP_NP_BIT] == $past(partner_next_page_able))
        else $error("partner next page wrong");
    local_np_a: assert property (@(posedge clk_sys) disable iff (reset)
        rd_exp |=> !reg_rdata[phyanr_pkg::EXP_LOC_NP_BIT])
        else $error("local next page not zero");
    page_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (page_received_event ##1 (rd_exp && !page_received_event))
        |=> reg_rdata[phyanr_pkg::EXP_PAGE_BIT] && !page_latch)
        else $error("page bit sequence wrong");
    partner_an_a: assert property (@(posedge clk_sys) disable iff (reset)
        rd_exp |=> reg_rdata[phyanr_pkg::EXP_LP_AN_BIT] == $past(partner_autoneg_able))
        else $error("partner autoneg wrong");
    coder_bypass_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_cfg && reg_wdata[phyanr_pkg::CFG_CODER_BIT]) |=> ##1 bypass_block_coder)
        else $error("coder bypass missing");
    scr_bypass_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_cfg && reg_wdata[phyanr_pkg::CFG_SCR_BIT]) |=> ##1 (bypass_scrambler && bypass_descrambler))
        else $error("scrambler bypass missing");
    align_bypass_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_cfg && reg_wdata[phyanr_pkg::CFG_ALIGN_BIT])
        |=> ##1 (bypass_symbol_alignment && bypass_symbol_coding && bypass_scrambler))
        else $error("alignment bypass missing");
    force_sd_a: assert property (@(posedge clk_sys) disable iff (reset)
        cfg[phyanr_pkg::CFG_SD_BIT] |=> signal_detect)
        else $error("signal detect not forced");
    tx_bit_a: assert property (@(posedge clk_sys) disable iff (reset)
        (reg_read && reg_addr == phyanr_pkg::ADDR_CONFIG) |=> reg_rdata[phyanr_pkg::CFG_TX_BIT])
        else $error("technology bit not one");
    force_link_a: assert property (@(posedge clk_sys) disable iff (reset)
        cfg[phyanr_pkg::CFG_FLINK_BIT] |=> link_100_good)
        else $error("link not forced");
    power_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
        !cfg[phyanr_pkg::CFG_APD_BIT] |=> !auto_power_reduce)
        else $error("power reduction while disabled");
    state_machine_reset_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_cfg && reg_wdata[phyanr_pkg::CFG_STATE_MACHINE_RESET_BIT]) |=> ##1 state_machine_reset[*8] ##1 !state_machine_reset)
        else $error("machine reset pulse wrong");
    preamble_a: assert property (@(posedge clk_sys) disable iff (reset)
        mgmt_preamble_suppress == $past(cfg[phyanr_pkg::CFG_PRE_BIT]))
        else $error("preamble control mismatch");
    wake_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
        wake_reset |=> ##1 (state_machine_reset && !sleep_power_down))
        else $error("wake without machine reset");
    loopout_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_cfg && reg_wdata[phyanr_pkg::CFG_LOOP_BIT]) |=> ##1 remote_loopout)
        else $error("loopout not set");

    // status read with no event beside it, so the clear must win
    sequence quiet_status_read_s;
        rd_irq && !parallel_fault_event && !page_received_event;
    endsequence

    sequence mask_write_s;
        reg_write && reg_addr == phyanr_pkg::ADDR_IRQ_MASK;
    endsequence

    sequence cfg_read_s;
        reg_read && reg_addr == phyanr_pkg::ADDR_CONFIG;
    endsequence

    irq_fault_a: assert property (@(posedge clk_sys) disable iff (reset)
        (parallel_fault_event && irq_mask[phyanr_pkg::IRQ_FAULT_BIT]) |=> irq)
        else $error("fault interrupt missing");

    irq_page_a: assert property (@(posedge clk_sys) disable iff (reset)
        (page_received_event && irq_mask[phyanr_pkg::IRQ_PAGE_BIT]) |=> irq)
        else $error("page interrupt missing");

    irq_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        quiet_status_read_s |=> !irq)
        else $error("interrupt not cleared by read");

    status_read_a: assert property (@(posedge clk_sys) disable iff (reset)
        rd_irq |=> reg_rdata[1:0] == $past(irq_status))
        else $error("status read wrong");

    mask_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        mask_write_s |=> irq_mask == $past(reg_wdata[1:0]))
        else $error("mask write lost");

    rdata_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data without read");

    exp_reserved_a: assert property (@(posedge clk_sys) disable iff (reset)
        rd_exp |=> reg_rdata[15:5] == 11'h000)
        else $error("expansion reserved bits set");

    cfg_reserved_a: assert property (@(posedge clk_sys) disable iff (reset)
        cfg_read_s |=> !reg_rdata[11] && reg_rdata[9:8] == 2'h0 && reg_rdata[6:5] == 2'h0)
        else $error("config reserved bits set");

    cfg_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        wr_cfg |=> (cfg & phyanr_pkg::CFG_WRITE_MASK)
                   == ($past(reg_wdata) & phyanr_pkg::CFG_WRITE_MASK))
        else $error("config write lost");

    fault_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        parallel_fault_event |=> fault_latch)
        else $error("fault latch not set");

    page_set_a: assert property (@(posedge clk_sys) disable iff (reset)
        page_received_event |=> page_latch)
        else $error("page latch not set");

    fault_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        (fault_latch && !rd_exp) |=> fault_latch)
        else $error("fault latch dropped");

    page_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
        (page_latch && !rd_exp) |=> page_latch)
        else $error("page latch dropped");

    sd_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        line_signal_detect |=> signal_detect)
        else $error("signal detect not passed");

    link_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        line_link_100_ok |=> link_100_good)
        else $error("link not passed");

    power_on_a: assert property (@(posedge clk_sys) disable iff (reset)
        (idle_power_condition && cfg[phyanr_pkg::CFG_APD_BIT]) |=> auto_power_reduce)
        else $error("power reduction missing");

    power_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
        !idle_power_condition |=> !auto_power_reduce)
        else $error("power reduction without idle");

    sleep_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        sleep_power_down == $past(cfg[phyanr_pkg::CFG_SLEEP_BIT]))
        else $error("sleep output mismatch");

    loop_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        remote_loopout == $past(cfg[phyanr_pkg::CFG_LOOP_BIT]))
        else $error("loopout output mismatch");

    smr_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        state_machine_reset == $past(state_machine_reset_busy))
        else $error("machine reset output mismatch");

    state_machine_reset_load_a: assert property (@(posedge clk_sys) disable iff (reset)
        (wr_cfg && reg_wdata[phyanr_pkg::CFG_STATE_MACHINE_RESET_BIT])
        |=> state_machine_reset_count == phyanr_pkg::STATE_MACHINE_RESET_CYCLES)
        else $error("machine reset count not loaded");

    state_machine_reset_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_machine_reset_count == 4'h1 && !wr_cfg) |=> !cfg[phyanr_pkg::CFG_STATE_MACHINE_RESET_BIT])
        else $error("machine reset bit not cleared");

    wake_load_a: assert property (@(posedge clk_sys) disable iff (reset)
        wake_reset |=> state_machine_reset_count == phyanr_pkg::STATE_MACHINE_RESET_CYCLES)
        else $error("wake count not loaded");

    coder_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        bypass_block_coder == $past(cfg[phyanr_pkg::CFG_CODER_BIT]
                                    || cfg[phyanr_pkg::CFG_ALIGN_BIT]))
        else $error("coder bypass mismatch");

    scr_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        bypass_descrambler == $past(cfg[phyanr_pkg::CFG_SCR_BIT]
                                    || cfg[phyanr_pkg::CFG_ALIGN_BIT]))
        else $error("descrambler bypass mismatch");

    align_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
        bypass_symbol_alignment == $past(cfg[phyanr_pkg::CFG_ALIGN_BIT]))
        else $error("alignment bypass mismatch");

    tx_const_a: assert property (@(posedge clk_sys) disable iff (reset)
        cfg_read_s |=> reg_rdata[phyanr_pkg::CFG_TX_BIT] && !reg_rdata[11])
        else $error("technology field wrong");
endmodule : phyanr_regs
`default_nettype wire

/* File: verif/phyanr_sme.sv */
`timescale 1ns/1ps
`default_nettype none
module phyanr_sme (
    input  wire logic        clk_sys,
    input  wire logic [15:0] reg_rdata,
    output logic      [4:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_write,
    output logic             reg_read
);
    initial begin
        reg_addr  = 5'h00;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read  = 1'b0;
    end
    // whole words by register number
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
endmodule : phyanr_sme
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [15:0] WV [10] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0080,
                                         16'h0010, 16'h0004, 16'h0002, 16'h0001, 16'h0F60};
    localparam logic [10:0] OV [10] = '{11'h400, 11'h300, 11'h7C0, 11'h020, 11'h010,
                                         11'h008, 11'h004, 11'h002, 11'h001, 11'h000};
    logic        clk_sys = 1'b0;
    logic        reset   = 1'b1;
    logic [4:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic        reg_write, reg_read, smr, irq;
    logic        pf = 1'b0, pr = 1'b0, pnp = 1'b0, pan = 1'b0, idle = 1'b0;
    logic        lsd = 1'b0, llk = 1'b0;
    logic [10:0] outs;
    int          miscompares = 0, n_checks = 0, n;
    always #5 clk_sys = ~clk_sys;
    phyanr_sme phyanr_sme_i (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
    phyanr_regs phyanr_regs_i (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .parallel_fault_event(pf), .page_received_event(pr),
        .partner_next_page_able(pnp), .partner_autoneg_able(pan),
        .line_signal_detect(lsd), .line_link_100_ok(llk), .idle_power_condition(idle),
        .bypass_block_coder(outs[10]), .bypass_scrambler(outs[9]),
        .bypass_descrambler(outs[8]), .bypass_symbol_alignment(outs[7]),
        .bypass_symbol_coding(outs[6]), .signal_detect(outs[5]), .link_100_good(outs[4]),
        .auto_power_reduce(outs[3]), .state_machine_reset(smr),
        .mgmt_preamble_suppress(outs[2]), .sleep_power_down(outs[1]),
        .remote_loopout(outs[0]), .irq(irq));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdchk(input string nm, input logic [4:0] a, input logic [15:0] e);
        phyanr_sme_i.rd(a, d);
        chk(nm, e, d);
    endtask : rdchk
    task automatic pulse(input bit page);
        @(posedge clk_sys);
        if (page) pr <= 1'b1; else pf <= 1'b1;
        @(posedge clk_sys);
        pr <= 1'b0;
        pf <= 1'b0;
        #1;
    endtask : pulse
    task automatic count_smr(input string nm);
        n = 0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            if (smr === 1'b1) n++;
        end
        chk(nm, 16'h0008, 16'(n));
    endtask : count_smr
    task automatic t_reset;
        rdchk("exp_reset", 5'h06, 16'h0000);
        rdchk("cfg_reset", 5'h10, 16'h0410);
        chk("outs_reset", 16'h0000, {3'b000, outs, smr, irq});
    endtask : t_reset
    task automatic t_expansion;
        pnp <= 1'b1;
        pan <= 1'b1;
        rdchk("exp_partner", 5'h06, 16'h0009);
        pulse(1'b0);
        pulse(1'b1);
        rdchk("exp_latched", 5'h06, 16'h001B);
        chk("irq_masked", 16'h0000, {15'h0000, irq});
        rdchk("exp_cleared", 5'h06, 16'h0009);
        pnp <= 1'b0;
        pan <= 1'b0;
        phyanr_sme_i.wr(5'h06, 16'h001F);
        rdchk("exp_readonly", 5'h06, 16'h0000);
    endtask : t_expansion
    task automatic t_config;
        idle <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            phyanr_sme_i.wr(5'h10, WV[i]);
            repeat (2) @(posedge clk_sys);
            #1;
            chk("cfg_outs", {5'h00, OV[i]}, {5'h00, outs});
            rdchk("cfg_read", 5'h10, (WV[i] & 16'hF09F) | 16'h0400);
        end
        lsd <= 1'b1;
        llk <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("line_follow", 16'h0030, {5'h00, outs & 11'h030});
        lsd <= 1'b0;
        llk <= 1'b0;
    endtask : t_config
    task automatic t_state_machine_reset;
        phyanr_sme_i.wr(5'h10, 16'h0008);
        count_smr("state_machine_reset_len");
        rdchk("state_machine_reset_clear", 5'h10, 16'h0400);
        phyanr_sme_i.wr(5'h10, 16'h0002);
        phyanr_sme_i.wr(5'h10, 16'h0000);
        count_smr("wake_len");
        chk("wake_sleep", 16'h0000, {15'h0000, outs[1]});
    endtask : t_state_machine_reset
    task automatic t_irq;
        rdchk("irq_sticky", 5'h1E, 16'h0003);
        rdchk("irq_cleared", 5'h1E, 16'h0000);
        phyanr_sme_i.wr(5'h1F, 16'h0001);
        pulse(1'b1);
        chk("irq_page_masked", 16'h0000, {15'h0000, irq});
        pulse(1'b0);
        chk("irq_fault", 16'h0001, {15'h0000, irq});
        rdchk("irq_mask", 5'h1F, 16'h0001);
        rdchk("irq_both", 5'h1E, 16'h0003);
        chk("irq_after_read", 16'h0000, {15'h0000, irq});
        rdchk("unmapped", 5'h05, 16'h0000);
    endtask : t_irq
    task automatic complete_run;
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset;
        t_expansion;
        t_config;
        t_state_machine_reset;
        t_irq;
        complete_run;
    end
endmodule : tb
`default_nettype wire
